/* adcc_cfg.svh */
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define ADCC_OFS_CTRL        8'h00
`define ADCC_OFS_STATUS      8'h04
`define ADCC_CTRL_RESET      32'h0000_0000

// CTRL fields
`define ADCC_CTRL_EXT        0
`define ADCC_CTRL_LEVEL      1
`define ADCC_CTRL_EDGE_LO    2
`define ADCC_CTRL_EDGE_HI    3
`define ADCC_CTRL_FSR_LO     4
`define ADCC_CTRL_FSR_HI     6
`define ADCC_CTRL_POWER_UP_CAL_DELAY_SELECT     7

// STATUS fields
`define ADCC_STAT_CALACT     0
`define ADCC_STAT_PDOWN      1
`define ADCC_STAT_OVR        2
`define ADCC_STAT_HOLD       3

// ----------------------------------------------------------------------
// Timing counts in REF_CLK cycles
// ----------------------------------------------------------------------
`define ADCC_CAL_LOW_CYC     16'd80
`define ADCC_CAL_HIGH_CYC    16'd80
`define ADCC_TRIM_CYC        16'd64
`define ADCC_CALIB_CYC       16'd256
`define ADCC_PU_SHORT_CYC    1024
`define ADCC_PU_LONG_CYC     8192
`define ADCC_BOOT_CYC        2'd3

// ----------------------------------------------------------------------
// Pipeline
// ----------------------------------------------------------------------
`define ADCC_PRI_DEPTH       12
`define ADCC_FULL_GAIN       4'd8
`define ADCC_LOW_FSR_GAIN    4'd10
`define ADCC_MID_CODE        11'sd128

`endif

/* adcc_pkg.sv */
package adcc_pkg;

  typedef enum logic [6:0] {
    ST_BOOT    = 7'b000_0001,
    ST_PU_WAIT = 7'b000_0010,
    ST_HOLD    = 7'b000_0100,
    ST_TRIM    = 7'b000_1000,
    ST_CALIB   = 7'b001_0000,
    ST_ACTIVE  = 7'b010_0000,
    ST_PDOWN   = 7'b100_0000
  } adcc_state_e;

  // Three-level pin code: 00 low, 11 high, 01 mid-supply, 10 floating
  typedef logic [1:0] adcc_tri_t;

  // Output word with its clip flag
  typedef logic [8:0] adcc_word_t;

endpackage : adcc_pkg

/* adcc_sync.sv */
`timescale 1ns/1ps
module adcc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule : adcc_sync

/* adcc_delay.sv */
`timescale 1ns/1ps
module adcc_delay #(
  parameter int W     = 18,
  parameter int DEPTH = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] pipe_q [DEPTH];
  logic [W-1:0] pipe_d [DEPTH];

  always_comb begin
    pipe_d[0] = d;
    for (int i = 1; i < DEPTH; i++) begin
      pipe_d[i] = pipe_q[i-1];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        pipe_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        pipe_q[i] <= pipe_d[i];
      end
    end
  end

  assign q = pipe_q[DEPTH-1];
endmodule : adcc_delay

/* adcc_top.sv */
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "adcc_cfg.svh"
module adcc_top #(
  parameter int PU_SHORT_CYC = `ADCC_PU_SHORT_CYC,
  parameter int PU_LONG_CYC  = `ADCC_PU_LONG_CYC
) (
  input  wire logic              REF_CLK,
  input  wire logic              RST_B,
  input  wire logic signed [9:0] I_SAMPLE,
  input  wire logic signed [9:0] Q_SAMPLE,
  input  wire logic              CAL_REQUEST,
  input  wire logic              POWER_DOWN_INPUT,
  input  wire logic              POWER_UP_CAL_DELAY_SELECT,
  input  wire logic              FULL_SCALE_RANGE_SELECT,
  input  wire logic              OUTPUT_LEVEL_SELECT,
  input  wire logic [1:0]        OUTPUT_EDGE_RATE_SELECT,
  output logic [7:0]             I_PRIMARY_BUS,
  output logic [7:0]             I_DELAYED_BUS,
  output logic [7:0]             Q_PRIMARY_BUS,
  output logic [7:0]             Q_DELAYED_BUS,
  output logic                   DATA_OE_B,
  output logic                   OUT_OF_RANGE,
  output logic                   FORWARDED_OUTPUT_CLOCK,
  output logic                   CALIBRATION_ACTIVE,
  output logic                   OUTPUT_LEVEL,
  output logic [1:0]             OUTPUT_EDGE_RATE,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [7:0]        S_AXI_AWADDR,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  output logic [1:0]             S_AXI_BRESP,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  input  wire logic [7:0]        S_AXI_ARADDR,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [6:0] pins_s;
  logic       cal_s;
  logic       pd_s;
  logic       dly_s;
  logic       fsr_s;
  logic       lvl_s;
  adcc_pkg::adcc_tri_t edge_s;

  adcc_sync #(.W(7)) u_sync (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .d     ({CAL_REQUEST, POWER_DOWN_INPUT, POWER_UP_CAL_DELAY_SELECT,
             FULL_SCALE_RANGE_SELECT, OUTPUT_LEVEL_SELECT, OUTPUT_EDGE_RATE_SELECT}),
    .q     (pins_s)
  );
  assign {cal_s, pd_s, dly_s, fsr_s, lvl_s, edge_s} = pins_s;

  // --------------------------------------------------------------------
  // Settings: pins or registers
  // --------------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic        ext;
  logic [1:0]  edge_pin;
  logic [3:0]  gain;
  logic        dly_long;

  assign ext = ctrl_q[`ADCC_CTRL_EXT];
  // Mid-supply decodes exactly as floating
  assign edge_pin = (edge_s == 2'h0) ? 2'h0 : (edge_s == 2'h3) ? 2'h1 : 2'h2;
  assign OUTPUT_LEVEL     = ext ? ctrl_q[`ADCC_CTRL_LEVEL] : lvl_s;
  assign OUTPUT_EDGE_RATE = ext ? ctrl_q[`ADCC_CTRL_EDGE_HI:`ADCC_CTRL_EDGE_LO]
                                : edge_pin;
  assign dly_long = ext ? ctrl_q[`ADCC_CTRL_POWER_UP_CAL_DELAY_SELECT] : dly_s;
  assign gain = ext ? (`ADCC_FULL_GAIN + {1'b0, ctrl_q[`ADCC_CTRL_FSR_HI:`ADCC_CTRL_FSR_LO]})
                    : (fsr_s ? `ADCC_FULL_GAIN : `ADCC_LOW_FSR_GAIN);

  // --------------------------------------------------------------------
  // Calibration command detector
  // --------------------------------------------------------------------
  logic [15:0] lo_cnt_q;
  logic [15:0] lo_cnt_d;
  logic [15:0] hi_cnt_q;
  logic [15:0] hi_cnt_d;
  logic        armed_q;
  logic        armed_d;
  logic        cmd_valid;
  logic        pd_eff;

  always_comb begin
    lo_cnt_d  = lo_cnt_q;
    hi_cnt_d  = hi_cnt_q;
    armed_d   = armed_q;
    cmd_valid = 1'b0;
    if (pd_eff) begin
      lo_cnt_d = '0;
      hi_cnt_d = '0;
      armed_d  = 1'b0;
    end else if (!cal_s) begin
      hi_cnt_d = '0;
      if (lo_cnt_q != 16'hffff) begin
        lo_cnt_d = lo_cnt_q + 16'h1;
      end
      if (lo_cnt_q >= `ADCC_CAL_LOW_CYC - 16'h1) begin
        armed_d = 1'b1;
      end
    end else begin
      lo_cnt_d = '0;
      if (armed_q) begin
        hi_cnt_d = hi_cnt_q + 16'h1;
        if (hi_cnt_q == `ADCC_CAL_HIGH_CYC - 16'h1) begin
          cmd_valid = 1'b1;
          armed_d   = 1'b0;
          hi_cnt_d  = '0;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      lo_cnt_q <= '0;
      hi_cnt_q <= '0;
      armed_q  <= 1'b0;
    end else begin
      lo_cnt_q <= lo_cnt_d;
      hi_cnt_q <= hi_cnt_d;
      armed_q  <= armed_d;
    end
  end

  // --------------------------------------------------------------------
  // Calibration sequencer
  // --------------------------------------------------------------------
  adcc_pkg::adcc_state_e st_q;
  adcc_pkg::adcc_state_e st_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [1:0]  boot_q;
  logic [1:0]  boot_d;
  logic        hold_q;
  logic        hold_d;
  logic [15:0] pu_cyc;

  assign pu_cyc = dly_long ? 16'(PU_LONG_CYC) : 16'(PU_SHORT_CYC);
  assign pd_eff = (st_q == adcc_pkg::ST_PDOWN) | (pd_s & (st_q != adcc_pkg::ST_TRIM)
                  & (st_q != adcc_pkg::ST_CALIB));

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    boot_d = boot_q;
    hold_d = hold_q;
    case (st_q)
      adcc_pkg::ST_BOOT: begin
        boot_d = boot_q + 2'h1;
        if (boot_q == `ADCC_BOOT_CYC) begin
          hold_d = cal_s;
          cnt_d  = '0;
          st_d   = adcc_pkg::ST_PU_WAIT;
        end
      end
      adcc_pkg::ST_PU_WAIT: begin
        if (!pd_s) begin
          cnt_d = cnt_q + 16'h1;
          if (cnt_q >= pu_cyc - 16'h1) begin
            cnt_d = '0;
            st_d  = hold_q ? adcc_pkg::ST_HOLD : adcc_pkg::ST_TRIM;
          end
        end
      end
      adcc_pkg::ST_HOLD: begin
        if (cmd_valid) begin
          hold_d = 1'b0;
          st_d   = adcc_pkg::ST_TRIM;
        end
      end
      adcc_pkg::ST_TRIM: begin
        cnt_d = cnt_q + 16'h1;
        if (cnt_q == `ADCC_TRIM_CYC - 16'h1) begin
          cnt_d = '0;
          st_d  = adcc_pkg::ST_CALIB;
        end
      end
      adcc_pkg::ST_CALIB: begin
        cnt_d = cnt_q + 16'h1;
        if (cnt_q == `ADCC_CALIB_CYC - 16'h1) begin
          cnt_d = '0;
          st_d  = pd_s ? adcc_pkg::ST_PDOWN : adcc_pkg::ST_ACTIVE;
        end
      end
      adcc_pkg::ST_ACTIVE: begin
        if (pd_s) begin
          st_d = adcc_pkg::ST_PDOWN;
        end else if (cmd_valid) begin
          st_d = adcc_pkg::ST_TRIM;
        end
      end
      adcc_pkg::ST_PDOWN: begin
        if (!pd_s) begin
          st_d = adcc_pkg::ST_ACTIVE;
        end
      end
      default: begin
        st_d = adcc_pkg::ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q   <= adcc_pkg::ST_BOOT;
      cnt_q  <= '0;
      boot_q <= '0;
      hold_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      boot_q <= boot_d;
      hold_q <= hold_d;
    end
  end

  assign CALIBRATION_ACTIVE = (st_q == adcc_pkg::ST_TRIM) | (st_q == adcc_pkg::ST_CALIB);

  // --------------------------------------------------------------------
  // Conversion, clipping and demultiplexing
  // --------------------------------------------------------------------
  function automatic adcc_pkg::adcc_word_t adcc_code(input logic signed [9:0] raw,
                                                     input logic [3:0] g);
    logic signed [14:0] prod;
    logic signed [10:0] scaled;
    prod   = raw * $signed({1'b0, g});
    scaled = 11'(prod >>> 3);
    if (scaled < -`ADCC_MID_CODE) begin
      adcc_code = {1'b1, 8'h00};
    end else if (scaled > `ADCC_MID_CODE - 11'sd1) begin
      adcc_code = {1'b1, 8'hff};
    end else begin
      adcc_code = {1'b0, 8'(scaled + `ADCC_MID_CODE)};
    end
  endfunction : adcc_code

  adcc_pkg::adcc_word_t i_code_q;
  adcc_pkg::adcc_word_t q_code_q;
  logic [17:0] pri_w;
  logic [17:0] del_w;
  logic        fclk_q;
  logic        fclk_d;
  logic        halt;
  logic        upd;
  logic        upd_q;
  logic [33:0] out_q;
  logic [33:0] out_d;

  // Same gain for both channels
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      i_code_q <= '0;
      q_code_q <= '0;
    end else begin
      i_code_q <= adcc_code(I_SAMPLE, gain);
      q_code_q <= adcc_code(Q_SAMPLE, gain);
    end
  end

  adcc_delay #(.W(18), .DEPTH(`ADCC_PRI_DEPTH)) u_pri (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .d     ({i_code_q, q_code_q}),
    .q     (pri_w)
  );
  adcc_delay #(.W(18), .DEPTH(1)) u_del (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .d     (pri_w),
    .q     (del_w)
  );

  assign halt   = (st_q == adcc_pkg::ST_TRIM) | (st_q == adcc_pkg::ST_PDOWN);
  assign fclk_d = halt ? fclk_q : ~fclk_q;
  assign upd    = ~halt & fclk_q;

  always_comb begin
    out_d = out_q;
    if (upd) begin
      out_d = {pri_w[7:0], del_w[7:0], pri_w[16:9], del_w[16:9],
               pri_w[17] | pri_w[8] | del_w[17] | del_w[8], 1'b0};
    end
    out_d[0] = pd_eff;
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      fclk_q <= 1'b0;
      upd_q  <= 1'b0;
      out_q  <= '0;
    end else begin
      fclk_q <= fclk_d;
      upd_q  <= upd;
      out_q  <= out_d;
    end
  end

  assign {Q_PRIMARY_BUS, Q_DELAYED_BUS, I_PRIMARY_BUS, I_DELAYED_BUS,
          OUT_OF_RANGE, DATA_OE_B} = out_q;
  assign FORWARDED_OUTPUT_CLOCK = fclk_q;

  // --------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [31:0] status;

  assign status = {28'h0, hold_q, OUT_OF_RANGE, st_q == adcc_pkg::ST_PDOWN,
                   CALIBRATION_ACTIVE};
  assign S_AXI_AWREADY = ~aw_q & ~bv_q;
  assign S_AXI_WREADY  = ~w_q & ~bv_q;
  assign S_AXI_ARREADY = ~rv_q;

  always_comb begin
    aw_d = aw_q; w_d = w_q; bv_d = bv_q; rv_d = rv_q;
    awa_d = awa_q; wd_d = wd_q; rd_d = rd_q; br_d = br_q; rr_d = rr_q;
    ctrl_d = ctrl_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_d  = 1'b1;
      awa_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_d  = 1'b1;
      wd_d = S_AXI_WDATA & {24'h0, {8{S_AXI_WSTRB[0]}}};
    end
    if (aw_q && w_q) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = 2'h2;
      if (awa_q == `ADCC_OFS_CTRL) begin
        ctrl_d = {24'h0, (wd_q[7:0] & {8{S_AXI_WSTRB[0]}}) |
                 (ctrl_q[7:0] & ~{8{S_AXI_WSTRB[0]}})};
        br_d   = 2'h0;
      end else if (awa_q == `ADCC_OFS_STATUS) begin
        br_d = 2'h0;
      end
    end
    if (bv_q && S_AXI_BREADY) begin
      bv_d = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rv_d = 1'b1;
      rr_d = 2'h0;
      rd_d = '0;
      case (S_AXI_ARADDR)
        `ADCC_OFS_CTRL:   rd_d = ctrl_q;
        `ADCC_OFS_STATUS: rd_d = status;
        default:          rr_d = 2'h2;
      endcase
    end else if (rv_q && S_AXI_RREADY) begin
      rv_d = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
      awa_q <= '0; wd_q <= '0; rd_q <= '0; br_q <= '0; rr_q <= '0;
      ctrl_q <= `ADCC_CTRL_RESET;
    end else begin
      aw_q <= aw_d; w_q <= w_d; bv_q <= bv_d; rv_q <= rv_d;
      awa_q <= awa_d; wd_q <= wd_d; rd_q <= rd_d; br_q <= br_d; rr_q <= rr_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign S_AXI_BVALID = bv_q;
  assign S_AXI_BRESP  = br_q;
  assign S_AXI_RVALID = rv_q;
  assign S_AXI_RDATA  = rd_q;
  assign S_AXI_RRESP  = rr_q;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  // Cycles since reset; a reset flushes the pipeline but not the sample history
  logic [3:0] warm_q;
  logic [3:0] warm_d;

  assign warm_d = (warm_q == 4'hf) ? warm_q : warm_q + 4'h1;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      warm_q <= '0;
    end else begin
      warm_q <= warm_d;
    end
  end

  sequence s_trim_end;
    st_q == adcc_pkg::ST_TRIM && cnt_q == `ADCC_TRIM_CYC - 16'h1;
  endsequence
  sequence s_calib_run;
    (st_q == adcc_pkg::ST_CALIB) [*8];
  endsequence

  a_clip_low_code: assert property (I_SAMPLE == -10'sd512 |=> i_code_q == 9'h100)
    else $error("negative overrange not clipped to zero");
  a_or_flag_merge: assert property (upd && (pri_w[17] || del_w[8]) |=> OUT_OF_RANGE)
    else $error("out-of-range flag missed a clip");
  a_pri_bus_latency: assert property (upd_q && warm_q > 4'd13 |->
                                      I_PRIMARY_BUS == $past(i_code_q[7:0], 13))
    else $error("primary bus latency wrong");
  a_del_bus_latency: assert property (upd_q && warm_q > 4'd13 |->
                                      Q_DELAYED_BUS == $past(q_code_q[7:0], 14))
    else $error("delayed bus latency wrong");
  a_cal_active_span: assert property (s_trim_end |=> s_calib_run ##0 CALIBRATION_ACTIVE)
    else $error("calibration active dropped early");
  a_trim_clk_halt: assert property (st_q == adcc_pkg::ST_TRIM && $past(st_q) ==
                                     adcc_pkg::ST_TRIM |-> $stable(fclk_q))
    else $error("forwarded clock ran during trim");
  a_pd_no_cal: assert property (st_q == adcc_pkg::ST_PDOWN |=> !CALIBRATION_ACTIVE)
    else $error("calibration started in power-down");
  a_pu_wait_frozen: assert property (st_q == adcc_pkg::ST_PU_WAIT && pd_s |=> $stable(cnt_q))
    else $error("power-up delay counted during power-down");
  a_ext_level_reg: assert property (ext |-> OUTPUT_LEVEL == ctrl_q[`ADCC_CTRL_LEVEL])
    else $error("extended mode used level pin");
  a_cmd_starts_cal: assert property (cmd_valid && st_q == adcc_pkg::ST_ACTIVE && !pd_s
                                     |=> st_q == adcc_pkg::ST_TRIM ##1 CALIBRATION_ACTIVE)
    else $error("valid command did not start calibration");
  a_cal_pd_finish: assert property (st_q == adcc_pkg::ST_CALIB && pd_s
                                    && cnt_q != `ADCC_CALIB_CYC - 16'h1
                                    |=> st_q == adcc_pkg::ST_CALIB)
    else $error("power-down cut calibration short");

endmodule : adcc_top

/* adcc_rx_model.sv */
`timescale 1ns/1ps
module adcc_rx_model (
  input  wire logic       clk,
  input  wire logic       fwd_clk,
  input  wire logic       cal_active,
  input  wire logic [7:0] pri_bus,
  input  wire logic [7:0] dly_bus,
  output logic            cal_req,
  output logic            range_sel,
  output logic [15:0]     pair_q
);
  logic fwd_q = 1'b0;

  initial begin
    cal_req = 1'b1;
    range_sel = 1'b1;
    pair_q = 16'h0000;
  end

  // ------------
  // Capture
  // ------------
  // Earlier word on the delayed bus, later word on the primary bus
  always @(posedge clk) begin
    fwd_q <= fwd_clk;
    if (fwd_q && !fwd_clk && !cal_active) begin
      pair_q <= {dly_bus, pri_bus};
    end
  end

  // ------------
  // Control pins
  // ------------
  // Commands a calibration, also releasing a held power-up calibration; runs exceed the minimum
  task automatic calibrate();
    cal_req <= 1'b0;
    repeat (82) @(posedge clk);
    cal_req <= 1'b1;
    repeat (84) @(posedge clk);
    cal_req <= 1'b0;
  endtask : calibrate

  task automatic set_range(input logic v);
    range_sel <= v;
    calibrate();
  endtask : set_range
endmodule : adcc_rx_model

/* adcc_top_tb.sv */
`timescale 1ns/1ps
module adcc_top_tb;
  localparam int PS = 8;
  localparam int PL = 16;
  logic              clk = 0, rst_b = 0, pd = 0, dsel = 0;
  logic signed [9:0] si = 0, sq = 0;
  logic        [1:0] edg = 0, br, rr, r, oedge;
  logic        [7:0] ip, id, qp, qd, awa = 0, ara = 0;
  logic       [31:0] wd = 0, rd, d;
  logic              awv = 0, wv = 0, bry = 1, arv = 0, rry = 1;
  logic              awr, wrd, bv, arr, rv, oe_b, oor, fwd, act, olvl, cal, full_scale_range_select;
  logic              fwd_p = 0, fwd_n = 0, lat_on = 0;
  logic       [15:0] pair;
  logic signed [9:0] hist [256];
  int                fail_count = 0, checks_done = 0;
  int                alen = 0, llen = 0, moves = 0, ec = 0, k, n, v, t [2];

  adcc_top #(.PU_SHORT_CYC(PS), .PU_LONG_CYC(PL)) i_adcc_top (
    .REF_CLK(clk), .RST_B(rst_b), .I_SAMPLE(si), .Q_SAMPLE(sq),
    .CAL_REQUEST(cal), .POWER_DOWN_INPUT(pd), .POWER_UP_CAL_DELAY_SELECT(dsel),
    .FULL_SCALE_RANGE_SELECT(full_scale_range_select), .OUTPUT_LEVEL_SELECT(1'b0),
    .OUTPUT_EDGE_RATE_SELECT(edg), .I_PRIMARY_BUS(ip), .I_DELAYED_BUS(id),
    .Q_PRIMARY_BUS(qp), .Q_DELAYED_BUS(qd), .DATA_OE_B(oe_b), .OUT_OF_RANGE(oor),
    .FORWARDED_OUTPUT_CLOCK(fwd), .CALIBRATION_ACTIVE(act), .OUTPUT_LEVEL(olvl),
    .OUTPUT_EDGE_RATE(oedge), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_BRESP(br),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr));

  adcc_rx_model i_adcc_rx_model (
    .clk(clk), .fwd_clk(fwd), .cal_active(act), .pri_bus(ip), .dly_bus(id),
    .cal_req(cal), .range_sel(full_scale_range_select), .pair_q(pair));

  initial forever #20 clk = ~clk;

  // ------------
  // Helpers
  // ------------
  task automatic final_report();
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  function automatic logic [7:0] oc(input int x);
    return 8'(x + 128);
  endfunction : oc

  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    awa <= a;
    wd <= x;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = br;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    chk(rd, e);
    chk(rr, er);
  endtask : rchk

  task automatic wact(input logic l, input int lim);
    for (n = 0; n < lim && act !== l; n++) @(posedge clk);
  endtask : wact

  task automatic calw();
    i_adcc_rx_model.calibrate();
    wact(1, 20);
    chk(n < 20, 1);
    wact(0, 400);
    repeat (2) @(posedge clk);
    chk(llen, 320);
  endtask : calw

  task automatic put(input int i, input int q);
    si <= 10'(i);
    sq <= 10'(q);
    repeat (40) @(posedge clk);
  endtask : put

  // ------------
  // Monitors
  // ------------
  always @(posedge clk) begin
    fwd_p <= fwd;
    if (act === 1'b1) begin
      alen <= alen + 1;
      if (alen > 1 && alen < 62 && fwd !== fwd_p) moves <= moves + 1;
    end else begin
      if (alen != 0) llen <= alen;
      alen <= 0;
    end
  end

  always @(negedge clk) begin
    fwd_n <= fwd;
    if (lat_on && fwd_n && !fwd) begin
      chk(ip, oc(hist[(ec - 13) & 255]));
      chk(id, oc(hist[(ec - 14) & 255]));
      chk(qp, oc(-hist[(ec - 13) & 255]));
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    final_report();
  end

  // ------------
  // Tests
  // ------------
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    wact(1, 300);
    chk(n, 300);
    rchk(8'h04, 32'h8, 2'b00);
    rchk(8'h00, 32'h0, 2'b00);
    rchk(8'h08, 32'h0, 2'b10);
    wr(8'h04, 32'hf);
    chk(r, 2'b00);
    calw();
    chk(moves, 0);
    for (k = 0; k < 120; k++) begin
      @(posedge clk);
      ec++;
      v = ec % 100 - 50;
      si <= 10'(v);
      sq <= 10'(-v);
      hist[(ec + 1) & 255] = 10'(v);
      lat_on <= (k > 20);
    end
    lat_on <= 1'b0;
    chk(8'(pair[7:0] - pair[15:8]), 1);
    put(300, 5);
    chk({ip, id, qp, oor}, {16'hffff, 8'h85, 1'b1});
    put(-512, -300);
    chk({ip, qd, oor}, {16'h0000, 1'b1});
    put(0, 0);
    chk({ip, oor}, {8'h80, 1'b0});
    i_adcc_rx_model.set_range(1'b0);
    wact(1, 20);
    wact(0, 400);
    put(80, -80);
    chk({ip, qp}, 16'he41c);
    i_adcc_rx_model.set_range(1'b1);
    wact(1, 20);
    wact(0, 400);
    for (k = 0; k < 4; k++) begin
      edg <= 2'(k);
      repeat (4) @(posedge clk);
      chk(oedge, (k == 0) ? 0 : (k == 3) ? 1 : 2);
    end
    edg <= 2'b00;
    wr(8'h00, 32'hffff_ff27);
    rchk(8'h00, 32'h27, 2'b00);
    put(80, -80);
    chk({olvl, oedge}, 3'b101);
    chk({ip, qp}, 16'he41c);
    pd <= 1'b1;
    repeat (5) @(posedge clk);
    i_adcc_rx_model.calibrate();
    wact(1, 50);
    chk(n, 50);
    chk(oe_b, 1);
    pd <= 1'b0;
    wact(1, 400);
    chk(n, 400);
    i_adcc_rx_model.calibrate();
    wact(1, 20);
    pd <= 1'b1;
    repeat (100) @(posedge clk);
    chk({act, oe_b}, 2'b10);
    wact(0, 400);
    repeat (5) @(posedge clk);
    chk(llen, 320);
    chk(oe_b, 1);
    for (k = 0; k < 2; k++) begin
      rst_b <= 1'b0;
      dsel <= k[0];
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      wact(1, 60);
      chk(n, 60);
      pd <= 1'b0;
      wact(1, 200);
      t[k] = n;
      wact(0, 400);
      pd <= 1'b1;
    end
    chk(t[0] < 200, 1);
    chk(t[1] - t[0], PL - PS);
    final_report();
  end
endmodule : adcc_top_tb
